// *** sbcs_pkg.sv ***
/*
  Package for the SDRAM bank command state tracker: command encodings,
  bank states and timing counts.
  Assumes a 250 MHz mclk; times are given in nanoseconds.
*/
package sbcs_pkg;
  localparam int NUM_BANKS = 4;
  localparam int BANK_W = 2;
  localparam int ADDR_W = 12;
  localparam int AP_BIT = 10;
  localparam int CNT_W = 8;
  localparam int CLK_PERIOD_PS = 4000;

  // Times in nanoseconds.
  localparam int PRECHARGE_TIME_NS = 20;
  localparam int ACTIVATE_TO_COLUMN_TIME_NS = 20;
  localparam int REFRESH_CYCLE_TIME_NS = 80;
  localparam int MODE_LOAD_TIME_NS = 8;
  localparam int SELF_REFRESH_EXIT_TIME_NS = 120;
  localparam int BURST_LEN = 4;

  // Least times round up, never below one cycle.
  function automatic int ns2cyc(input int ns);
    int c;
    c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam logic [CNT_W-1:0] PRECHARGE_CYC = CNT_W'(ns2cyc(PRECHARGE_TIME_NS));
  localparam logic [CNT_W-1:0] ACTIVATE_TO_COLUMN_CYC = CNT_W'(ns2cyc(ACTIVATE_TO_COLUMN_TIME_NS));
  localparam logic [CNT_W-1:0] REFRESH_CYCLE_CYC = CNT_W'(ns2cyc(REFRESH_CYCLE_TIME_NS));
  localparam logic [CNT_W-1:0] MODE_LOAD_CYC = CNT_W'(ns2cyc(MODE_LOAD_TIME_NS));
  localparam logic [CNT_W-1:0] SELF_REFRESH_EXIT_CYC = CNT_W'(ns2cyc(SELF_REFRESH_EXIT_TIME_NS));
  localparam logic [CNT_W-1:0] BURST_CYC = CNT_W'(BURST_LEN);

  // Command pins {cs_n, ras_n, cas_n, we_n}.
  typedef enum logic [3:0] {
    SBCS_CMD_NOP = 4'h7,
    SBCS_CMD_ACTIVE = 4'h3,
    SBCS_CMD_READ = 4'h5,
    SBCS_CMD_WRITE = 4'h4,
    SBCS_CMD_BTERM = 4'h6,
    SBCS_CMD_PRECH = 4'h2,
    SBCS_CMD_AREF = 4'h1,
    SBCS_CMD_LMR = 4'h0
  } sbcs_cmd_e;

  typedef enum logic [7:0] {
    SBCS_ST_IDLE = 8'h01,
    SBCS_ST_ACTIVATING = 8'h02,
    SBCS_ST_ACTIVE = 8'h04,
    SBCS_ST_READ = 8'h08,
    SBCS_ST_WRITE = 8'h10,
    SBCS_ST_PRECHARGING = 8'h20,
    SBCS_ST_AUTOPRE = 8'h40,
    SBCS_ST_GLOBAL = 8'h80
  } sbcs_state_e;

  typedef enum logic [4:0] {
    SBCS_G_NONE = 5'h01,
    SBCS_G_REFRESH = 5'h02,
    SBCS_G_MODE = 5'h04,
    SBCS_G_PREALL = 5'h08,
    SBCS_G_SRX = 5'h10
  } sbcs_global_e;
endpackage

// *** sbcs_if.sv ***
/*
  Command pins between memory controller and SDRAM bank tracker.
  Assumes one shared mclk; every pin is sampled on its rising edge.
*/
`timescale 1ns/1ps
interface sbcs_if;
  logic chipSelectN;
  logic rowStrobeN;
  logic columnStrobeN;
  logic writeEnableN;
  logic clockEnableIn;
  logic [sbcs_pkg::BANK_W-1:0] bankAddr;
  logic [sbcs_pkg::ADDR_W-1:0] addr;
  logic selfRefreshExit;
  modport dev (input chipSelectN, rowStrobeN, columnStrobeN, writeEnableN, clockEnableIn,
               bankAddr, addr, selfRefreshExit);
  modport ctl (output chipSelectN, rowStrobeN, columnStrobeN, writeEnableN, clockEnableIn,
               bankAddr, addr, selfRefreshExit);
endinterface

// *** sbcs_bank.sv ***
/*
  One bank's state register and its timer.
  Assumes command decode and global busy are provided by the device end.
*/
`timescale 1ns/1ps
module sbcs_bank
  import sbcs_pkg::*;
(
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst_n,
  // Decoded command for this bank.
  input wire logic cmdActive,
  input wire logic cmdRead,
  input wire logic cmdWrite,
  input wire logic cmdPrecharge,
  input wire logic cmdStop,
  input wire logic autoPre,
  // Global operation starting and its end.
  input wire logic globalBusy,
  input wire logic globalDone,
  // State.
  output sbcs_state_e state
);
  sbcs_state_e state_q, state_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  wire logic cntZero = (cnt_q == '0);

  always_comb begin
    state_d = state_q;
    cnt_d = cntZero ? cnt_q : cnt_q - 1'b1;
    case (state_q)
      SBCS_ST_IDLE: begin
        if (globalBusy) begin
          state_d = SBCS_ST_GLOBAL;
        end else if (cmdActive) begin
          state_d = SBCS_ST_ACTIVATING;
          cnt_d = ACTIVATE_TO_COLUMN_CYC - 1'b1;
        end
        // A precharge here does nothing.
      end
      SBCS_ST_ACTIVATING: begin
        if (cntZero) state_d = SBCS_ST_ACTIVE;
      end
      SBCS_ST_ACTIVE, SBCS_ST_READ, SBCS_ST_WRITE: begin
        if (globalBusy) begin
          state_d = SBCS_ST_GLOBAL;
        end else if (cmdPrecharge) begin
          state_d = SBCS_ST_PRECHARGING;
          cnt_d = PRECHARGE_CYC - 1'b1;
        end else if ((cmdRead || cmdWrite) && autoPre) begin
          state_d = SBCS_ST_AUTOPRE;
          cnt_d = BURST_CYC + PRECHARGE_CYC - 1'b1;
        end else if (cmdRead) begin
          state_d = SBCS_ST_READ;
          cnt_d = BURST_CYC - 1'b1;
        end else if (cmdWrite) begin
          state_d = SBCS_ST_WRITE;
          cnt_d = BURST_CYC - 1'b1;
        end else if (cmdStop) begin
          state_d = SBCS_ST_ACTIVE;
        end else if (state_q != SBCS_ST_ACTIVE && cntZero) begin
          state_d = SBCS_ST_ACTIVE;
        end
      end
      SBCS_ST_PRECHARGING, SBCS_ST_AUTOPRE: begin
        if (cntZero) state_d = SBCS_ST_IDLE;
      end
      SBCS_ST_GLOBAL: begin
        if (globalDone) state_d = SBCS_ST_IDLE;
      end
      default: state_d = SBCS_ST_IDLE;
    endcase
  end

  // Own state and counter per bank.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= SBCS_ST_IDLE;
      cnt_q <= '0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end

  assign state = state_q;
endmodule

// *** sbcs_device.sv ***
/*
  Device end: decodes SDRAM commands and tracks every bank's state plus
  global refresh, mode load, precharge-all and self refresh exit.
  Assumes the controller keeps its own command legality; a command that is
  illegal for a bank's state is not flagged, the bank simply keeps its state.
  Assumes every pin is synchronous to mclk and changes just after its rising edge.
*/
`timescale 1ns/1ps
module sbcs_device
  import sbcs_pkg::*;
(
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst_n,
  // Command pins.
  sbcs_if.dev pins,
  // Observed state.
  output logic [NUM_BANKS*8-1:0] bankStates,
  output logic allIdle,
  output logic deepPowerDown
);
  sbcs_global_e glob_q, glob_d;
  logic [CNT_W-1:0] gcnt_q, gcnt_d;
  logic ckePrev_q;
  logic [BANK_W-1:0] lastBurstBank_q;
  logic dpd_q;
  sbcs_state_e st [NUM_BANKS];

  wire sbcs_cmd_e cmd = sbcs_cmd_e'({pins.chipSelectN, pins.rowStrobeN, pins.columnStrobeN,
                                     pins.writeEnableN});
  // Decode only while clock enable is high now and was high before.
  wire logic decodeOk = ckePrev_q && pins.clockEnableIn && (glob_q == SBCS_G_NONE);
  // Deselect or NOP fall through as no command.
  wire logic live = decodeOk && !pins.chipSelectN;
  wire logic allPre = pins.addr[AP_BIT];
  wire logic isAct = live && cmd == SBCS_CMD_ACTIVE;
  wire logic isRd = live && cmd == SBCS_CMD_READ;
  wire logic isWr = live && cmd == SBCS_CMD_WRITE;
  wire logic isPre = live && cmd == SBCS_CMD_PRECH;
  wire logic isStop = live && cmd == SBCS_CMD_BTERM;
  wire logic isRef = live && cmd == SBCS_CMD_AREF && allIdle;
  wire logic isLmr = live && cmd == SBCS_CMD_LMR && allIdle;
  // A precharge-all with every bank idle starts no busy period; the banks just stay idle.
  wire logic isPreAll = isPre && allPre && !allIdle;
  wire logic gcntZero = (gcnt_q == '0);
  wire logic globalDone = (glob_q != SBCS_G_NONE) && gcntZero;
  wire logic globalStart = isRef || isLmr || isPreAll;
  wire logic dpdEntry = ckePrev_q && !pins.clockEnableIn && !pins.chipSelectN &&
                        cmd == SBCS_CMD_BTERM && allIdle;

  function automatic logic bankHit(input logic [BANK_W-1:0] b, input int i);
    return b == BANK_W'(i);
  endfunction

  genvar g;
  generate
    for (g = 0; g < NUM_BANKS; g++) begin : gBank
      wire logic hit = bankHit(pins.bankAddr, g);
      // Burst terminate goes to the bank of the latest burst, whatever bank the pins name.
      wire logic bankStop = isStop && bankHit(lastBurstBank_q, g);
      wire logic bankAct = isAct && hit;
      wire logic bankRd = isRd && hit;
      wire logic bankWr = isWr && hit;
      wire logic bankPre = isPre && hit && !allPre;
      sbcs_bank uBank (
        .mclk(mclk),
        .rst_n(rst_n),
        .cmdActive(bankAct),
        .cmdRead(bankRd),
        .cmdWrite(bankWr),
        .cmdPrecharge(bankPre),
        .cmdStop(bankStop),
        .autoPre(pins.addr[AP_BIT]),
        .globalBusy(globalStart),
        .globalDone(globalDone),
        .state(st[g])
      );
      assign bankStates[g*8 +: 8] = st[g];
    end
  endgenerate

  always_comb begin
    allIdle = 1'b1;
    for (int i = 0; i < NUM_BANKS; i++) begin
      if (st[i] != SBCS_ST_IDLE) allIdle = 1'b0;
    end
    if (glob_q != SBCS_G_NONE) allIdle = 1'b0;
  end

  always_comb begin
    glob_d = glob_q;
    gcnt_d = gcntZero ? gcnt_q : gcnt_q - 1'b1;
    case (glob_q)
      SBCS_G_NONE: begin
        if (pins.selfRefreshExit) begin
          glob_d = SBCS_G_SRX;
          gcnt_d = SELF_REFRESH_EXIT_CYC - 1'b1;
        end else if (isRef) begin
          glob_d = SBCS_G_REFRESH;
          gcnt_d = REFRESH_CYCLE_CYC - 1'b1;
        end else if (isLmr) begin
          glob_d = SBCS_G_MODE;
          gcnt_d = MODE_LOAD_CYC - 1'b1;
        end else if (isPreAll) begin
          glob_d = SBCS_G_PREALL;
          gcnt_d = PRECHARGE_CYC - 1'b1;
        end
      end
      SBCS_G_REFRESH, SBCS_G_MODE, SBCS_G_PREALL, SBCS_G_SRX: begin
        if (gcntZero) glob_d = SBCS_G_NONE;
      end
      default: glob_d = SBCS_G_NONE;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      glob_q <= SBCS_G_NONE;
      gcnt_q <= '0;
    end else begin
      glob_q <= glob_d;
      gcnt_q <= gcnt_d;
    end
  end

  // Cleared in reset, so the first edge after release never decodes a command.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ckePrev_q <= 1'b0;
    end else begin
      ckePrev_q <= pins.clockEnableIn;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      lastBurstBank_q <= '0;
    end else if (isRd || isWr) begin
      lastBurstBank_q <= pins.bankAddr;
    end
  end

  // Deep power-down holds until clock enable returns high; waking needs a fresh start-up outside this block.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dpd_q <= 1'b0;
    end else if (dpdEntry) begin
      dpd_q <= 1'b1;
    end else if (pins.clockEnableIn) begin
      dpd_q <= 1'b0;
    end
  end

  assign deepPowerDown = dpd_q;
endmodule

// *** sbcs_controller.sv ***
/*
  Controller end: drives one user request at a time onto the command pins,
  holding back requests to busy banks and during global operations.
  Assumes the user watches reqReady and keeps req steady until taken.
*/
`timescale 1ns/1ps
module sbcs_controller
  import sbcs_pkg::*;
(
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst_n,
  // User request.
  input wire logic reqValid,
  input sbcs_pkg::sbcs_cmd_e reqCmd,
  input wire logic [sbcs_pkg::BANK_W-1:0] reqBank,
  input wire logic [sbcs_pkg::ADDR_W-1:0] reqAddr,
  output logic reqReady,
  // Bank states seen by the controller.
  input wire logic [sbcs_pkg::NUM_BANKS*8-1:0] bankStates,
  input wire logic allIdle,
  // Pins.
  sbcs_if.ctl pins
);
  logic [3:0] cmd_q;
  logic [BANK_W-1:0] bank_q;
  logic [ADDR_W-1:0] addr_q;
  wire sbcs_state_e tgt = sbcs_state_e'(bankStates[reqBank*8 +: 8]);
  logic anyBusy;

  // Banks that are opening, closing or held by a global operation take no command.
  function automatic logic isBusy(input sbcs_state_e s);
    return s == SBCS_ST_ACTIVATING || s == SBCS_ST_PRECHARGING ||
           s == SBCS_ST_AUTOPRE || s == SBCS_ST_GLOBAL;
  endfunction

  always_comb begin
    anyBusy = 1'b0;
    for (int i = 0; i < NUM_BANKS; i++) begin
      if (isBusy(sbcs_state_e'(bankStates[i*8 +: 8]))) anyBusy = 1'b1;
    end
  end

  wire logic tgtBusy = isBusy(tgt);
  wire logic tgtOpen = tgt == SBCS_ST_ACTIVE || tgt == SBCS_ST_READ || tgt == SBCS_ST_WRITE;
  wire logic isGlobalCmd = reqCmd == SBCS_CMD_AREF || reqCmd == SBCS_CMD_LMR;
  wire logic isColumnCmd = reqCmd == SBCS_CMD_READ || reqCmd == SBCS_CMD_WRITE;
  wire logic isPreAllReq = reqCmd == SBCS_CMD_PRECH && reqAddr[AP_BIT];
  // Bank states lag the pins by one edge, so nothing new is taken while a command is still on them.
  wire logic pinsFree = cmd_q == SBCS_CMD_NOP;
  // Refresh and mode load wait for all idle, precharge-all for no busy bank.
  wire logic legal = isGlobalCmd ? allIdle :
                     (reqCmd == SBCS_CMD_ACTIVE) ? (tgt == SBCS_ST_IDLE) :
                     isColumnCmd ? tgtOpen :
                     isPreAllReq ? !anyBusy : !tgtBusy;
  assign reqReady = legal && pinsFree;
  wire logic take = reqValid && legal && pinsFree;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_q <= SBCS_CMD_NOP;
      bank_q <= '0;
      addr_q <= '0;
    end else begin
      cmd_q <= take ? reqCmd : SBCS_CMD_NOP;
      bank_q <= take ? reqBank : bank_q;
      addr_q <= take ? reqAddr : addr_q;
    end
  end

  assign pins.chipSelectN = cmd_q[3];
  assign pins.rowStrobeN = cmd_q[2];
  assign pins.columnStrobeN = cmd_q[1];
  assign pins.writeEnableN = cmd_q[0];
  assign pins.clockEnableIn = 1'b1;
  assign pins.bankAddr = bank_q;
  assign pins.addr = addr_q;
  assign pins.selfRefreshExit = 1'b0;
endmodule

// *** sbcs_assertions.sv ***
/*
  Assertions on the command pins and bank states of the tracker.
  Assumes the testbench instantiates it beside the interface; no bind.
*/
`timescale 1ns/1ps
module sbcs_assertions
  import sbcs_pkg::*;
(
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst_n,
  // Command pins.
  input wire logic chipSelectN,
  input wire logic rowStrobeN,
  input wire logic columnStrobeN,
  input wire logic writeEnableN,
  input wire logic clockEnableIn,
  input wire logic [sbcs_pkg::BANK_W-1:0] bankAddr,
  input wire logic [sbcs_pkg::ADDR_W-1:0] addr,
  // Device state.
  input wire logic [sbcs_pkg::NUM_BANKS*8-1:0] bankStates,
  input wire logic allIdle
);
  logic ckeQ;
  logic live;
  logic on0;
  logic ap;
  logic open0;
  logic burst0;
  logic othersIdle;
  logic [3:0] cmd;
  logic [7:0] st0;
  assign cmd = {chipSelectN, rowStrobeN, columnStrobeN, writeEnableN};
  assign st0 = bankStates[7:0];
  assign ap = addr[AP_BIT];
  assign live = clockEnableIn && ckeQ;
  assign on0 = live && bankAddr == 2'h0;
  assign burst0 = st0 == SBCS_ST_READ || st0 == SBCS_ST_WRITE;
  assign open0 = burst0 || st0 == SBCS_ST_ACTIVE;
  assign othersIdle = bankStates[NUM_BANKS*8-1:8] == {(NUM_BANKS-1){SBCS_ST_IDLE}};
  // Cleared in reset so the first edge after release never counts as a live decode.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ckeQ <= 1'b0;
    end else begin
      ckeQ <= clockEnableIn;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_idle_holds: assert property ((cmd[3] || cmd == SBCS_CMD_NOP) && st0 == SBCS_ST_ACTIVE |=>
    st0 == SBCS_ST_ACTIVE) else $error("active bank moved on idle cycle");
  a_activate_opens: assert property (on0 && cmd == SBCS_CMD_ACTIVE && st0 == SBCS_ST_IDLE |=>
    st0 == SBCS_ST_ACTIVATING [*5] ##1 st0 == SBCS_ST_ACTIVE) else $error("row open timing wrong");
  a_idle_precharge: assert property (on0 && cmd == SBCS_CMD_PRECH && !ap && st0 == SBCS_ST_IDLE |=>
    st0 == SBCS_ST_IDLE) else $error("idle bank precharge changed state");
  a_read_starts: assert property (on0 && cmd == SBCS_CMD_READ && !ap && open0 |=>
    st0 == SBCS_ST_READ) else $error("read burst not started");
  a_write_starts: assert property (on0 && cmd == SBCS_CMD_WRITE && !ap && open0 |=>
    st0 == SBCS_ST_WRITE) else $error("write burst not started");
  a_precharge_closes: assert property (on0 && cmd == SBCS_CMD_PRECH && !ap && open0 |=>
    st0 == SBCS_ST_PRECHARGING [*5] ##1 st0 == SBCS_ST_IDLE) else $error("precharge timing wrong");
  a_autopre_busy: assert property (on0 && (cmd == SBCS_CMD_READ || cmd == SBCS_CMD_WRITE) && ap &&
    st0 == SBCS_ST_ACTIVE |=> st0 == SBCS_ST_AUTOPRE [*8] ##1 st0 == SBCS_ST_AUTOPRE ##1 st0 == SBCS_ST_IDLE)
    else $error("auto precharge timing wrong");
  a_term_stops: assert property (live && cmd == SBCS_CMD_BTERM && burst0 && othersIdle |=>
    st0 == SBCS_ST_ACTIVE) else $error("burst terminate ignored");
  a_refresh_busy: assert property (live && cmd == SBCS_CMD_AREF && allIdle |=>
    !allIdle ##19 !allIdle ##1 allIdle) else $error("refresh busy time wrong");
  a_mode_busy: assert property (live && cmd == SBCS_CMD_LMR && allIdle |=>
    !allIdle [*2] ##1 allIdle) else $error("mode load busy time wrong");
  a_preall_busy: assert property (live && cmd == SBCS_CMD_PRECH && ap && !allIdle |=>
    !allIdle [*5] ##1 allIdle) else $error("precharge all busy time wrong");
  c_read: cover property (on0 && cmd == SBCS_CMD_READ && open0);
  c_refresh: cover property (live && cmd == SBCS_CMD_AREF);
  c_autopre: cover property (st0 == SBCS_ST_AUTOPRE);
endmodule

// *** sdram_bank_command_state_tb.sv ***
/*
  Testbench: controller and device joined by one interface, plus a second
  device driven straight from the bench to break the controller's side.
  Assumes the package timing counts and a 250 MHz mclk.
*/
`timescale 1ns/1ps
module sdram_bank_command_state_tb;
  import sbcs_pkg::*;
  localparam int ACT = int'(ACTIVATE_TO_COLUMN_CYC);
  localparam int PRE = int'(PRECHARGE_CYC);
  logic mclk;
  logic rst_n;
  logic reqValid;
  sbcs_cmd_e reqCmd;
  logic [BANK_W-1:0] reqBank;
  logic [ADDR_W-1:0] reqAddr;
  logic reqReady;
  logic [NUM_BANKS*8-1:0] bankStates;
  logic [NUM_BANKS*8-1:0] bankStatesB;
  logic allIdle;
  logic allIdleB;
  logic deepPowerDown;
  logic deepPowerDownB;
  int bad_count;
  int compares;
  sbcs_if p1();
  sbcs_if p2();
  sbcs_controller u_sbcs_controller (.mclk(mclk), .rst_n(rst_n), .reqValid(reqValid), .reqCmd(reqCmd),
    .reqBank(reqBank), .reqAddr(reqAddr), .reqReady(reqReady), .bankStates(bankStates), .allIdle(allIdle),
    .pins(p1.ctl));
  sbcs_device u_sbcs_device (.mclk(mclk), .rst_n(rst_n), .pins(p1.dev), .bankStates(bankStates),
    .allIdle(allIdle), .deepPowerDown(deepPowerDown));
  sbcs_device u_sbcs_device_b (.mclk(mclk), .rst_n(rst_n), .pins(p2.dev), .bankStates(bankStatesB),
    .allIdle(allIdleB), .deepPowerDown(deepPowerDownB));
  sbcs_assertions u_sbcs_assertions (.mclk(mclk), .rst_n(rst_n), .chipSelectN(p1.chipSelectN),
    .rowStrobeN(p1.rowStrobeN), .columnStrobeN(p1.columnStrobeN), .writeEnableN(p1.writeEnableN),
    .clockEnableIn(p1.clockEnableIn), .bankAddr(p1.bankAddr), .addr(p1.addr), .bankStates(bankStates),
    .allIdle(allIdle));
  function automatic logic [7:0] st(input int b);
    return bankStates[8*b +: 8];
  endfunction
  task automatic conclude();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic ck(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    @(negedge mclk);
  endtask
  // The request is held until the edge that takes it, then dropped at that edge.
  task automatic go(input sbcs_cmd_e c, input logic [1:0] b, input logic [11:0] a);
    int n;
    n = 0;
    @(posedge mclk);
    reqValid <= 1'b1;
    reqCmd <= c;
    reqBank <= b;
    reqAddr <= a;
    do begin
      @(negedge mclk);
      n++;
    end while (reqReady !== 1'b1 && n < 300);
    if (n >= 300) begin
      bad_count++;
      conclude();
    end
    @(posedge mclk);
    reqValid <= 1'b0;
  endtask
  task automatic step(input sbcs_cmd_e c, input logic [1:0] b, input logic [11:0] a, input int sb,
                      input string nm, input logic [7:0] exp);
    go(c, b, a);
    cyc(1);
    ck(nm, st(sb), exp);
  endtask
  task automatic pin(input logic [3:0] c, input logic k);
    @(posedge mclk);
    {p2.chipSelectN, p2.rowStrobeN, p2.columnStrobeN, p2.writeEnableN} <= c;
    p2.clockEnableIn <= k;
  endtask
  task automatic t_rows();
    step(SBCS_CMD_ACTIVE, 2'h0, 12'h0A5, 0, "open", SBCS_ST_ACTIVATING);
    ck("other", st(1), SBCS_ST_IDLE);
    @(posedge mclk);
    reqCmd <= SBCS_CMD_READ;
    reqBank <= 2'h0;
    @(negedge mclk);
    ck("busy_bank", 8'(reqReady), 8'h00);
    @(posedge mclk);
    reqBank <= 2'h1;
    @(negedge mclk);
    ck("idle_read", 8'(reqReady), 8'h00);
    cyc(ACT - 3);
    ck("opening", st(0), SBCS_ST_ACTIVATING);
    cyc(1);
    ck("opened", st(0), SBCS_ST_ACTIVE);
  endtask
  task automatic t_bursts();
    step(SBCS_CMD_READ, 2'h0, 12'h000, 0, "rd", SBCS_ST_READ);
    step(SBCS_CMD_WRITE, 2'h0, 12'h004, 0, "rd_wr", SBCS_ST_WRITE);
    step(SBCS_CMD_READ, 2'h0, 12'h008, 0, "wr_rd", SBCS_ST_READ);
    step(SBCS_CMD_BTERM, 2'h3, 12'h000, 0, "term", SBCS_ST_ACTIVE);
    step(SBCS_CMD_WRITE, 2'h0, 12'h000, 0, "wr", SBCS_ST_WRITE);
    step(SBCS_CMD_PRECH, 2'h0, 12'h000, 0, "cut", SBCS_ST_PRECHARGING);
    cyc(PRE - 1);
    ck("closing", st(0), SBCS_ST_PRECHARGING);
    cyc(1);
    ck("closed", st(0), SBCS_ST_IDLE);
  endtask
  task automatic t_autopre();
    step(SBCS_CMD_ACTIVE, 2'h0, 12'h000, 0, "reopen", SBCS_ST_ACTIVATING);
    cyc(ACT);
    step(SBCS_CMD_READ, 2'h0, 12'h400, 0, "auto", SBCS_ST_AUTOPRE);
    cyc(BURST_LEN + PRE - 1);
    ck("auto_busy", st(0), SBCS_ST_AUTOPRE);
    cyc(1);
    ck("auto_done", st(0), SBCS_ST_IDLE);
    step(SBCS_CMD_PRECH, 2'h2, 12'h000, 2, "pre_idle", SBCS_ST_IDLE);
    ck("all_idle", 8'(allIdle), 8'h01);
    ck("no_deep", 8'(deepPowerDown), 8'h00);
  endtask
  task automatic glob(input sbcs_cmd_e c, input logic [11:0] a, input int n);
    go(c, 2'h3, a);
    cyc(1);
    ck("busy", 8'(allIdle), 8'h00);
    cyc(n - 1);
    ck("still", 8'(allIdle), 8'h00);
    cyc(1);
    ck("done", 8'(allIdle), 8'h01);
  endtask
  // The second device sees commands the controller would never send.
  task automatic t_faults();
    pin(4'hB, 1'b1);
    pin(SBCS_CMD_NOP, 1'b1);
    cyc(0);
    ck("deselect", bankStatesB[7:0], SBCS_ST_IDLE);
    pin(SBCS_CMD_NOP, 1'b0);
    pin(SBCS_CMD_ACTIVE, 1'b1);
    pin(SBCS_CMD_NOP, 1'b1);
    cyc(0);
    ck("cke_low", bankStatesB[7:0], SBCS_ST_IDLE);
    pin(SBCS_CMD_ACTIVE, 1'b1);
    pin(SBCS_CMD_AREF, 1'b1);
    pin(SBCS_CMD_NOP, 1'b1);
    cyc(ACT - 1);
    ck("no_refresh", bankStatesB[7:0], SBCS_ST_ACTIVE);
    ck("no_refresh_b1", bankStatesB[15:8], SBCS_ST_IDLE);
    pin(SBCS_CMD_PRECH, 1'b1);
    pin(SBCS_CMD_NOP, 1'b1);
    cyc(PRE);
    ck("shut", bankStatesB[7:0], SBCS_ST_IDLE);
    pin(SBCS_CMD_BTERM, 1'b0);
    pin(SBCS_CMD_NOP, 1'b0);
    cyc(0);
    ck("deep", 8'(deepPowerDownB), 8'h01);
  endtask
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  initial begin
    rst_n = 1'b0;
    reqValid = 1'b0;
    reqCmd = SBCS_CMD_NOP;
    reqBank = 2'h0;
    reqAddr = 12'h000;
    {p2.chipSelectN, p2.rowStrobeN, p2.columnStrobeN, p2.writeEnableN} = 4'h7;
    p2.clockEnableIn = 1'b1;
    p2.bankAddr = 2'h0;
    p2.addr = 12'h000;
    p2.selfRefreshExit = 1'b0;
    bad_count = 0;
    compares = 0;
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    cyc(2);
    t_rows();
    t_bursts();
    t_autopre();
    glob(SBCS_CMD_AREF, 12'h000, int'(REFRESH_CYCLE_CYC));
    glob(SBCS_CMD_LMR, 12'h000, int'(MODE_LOAD_CYC));
    step(SBCS_CMD_ACTIVE, 2'h3, 12'h000, 3, "open3", SBCS_ST_ACTIVATING);
    cyc(ACT);
    glob(SBCS_CMD_PRECH, 12'h400, PRE);
    t_faults();
    conclude();
  end
endmodule
